// ### rtl/bmmd_params.svh
// constants of the banked memory map decoder
`ifndef BMMD_PARAMS_SVH
`define BMMD_PARAMS_SVH

// ----------------------------------------------------------------------
// program space
// ----------------------------------------------------------------------
`define BMMD_PC_W            13
`define BMMD_PROG_WORDS_DEF  4096
`define BMMD_RESET_VEC       13'h0000
`define BMMD_IRQ_VEC         13'h0004
`define BMMD_PC_ONE          13'h0001
`define BMMD_PROGRAM_COUNTER_LATCH_HIGH_PC_W     5

// ----------------------------------------------------------------------
// data space layout
// ----------------------------------------------------------------------
`define BMMD_GPR_BYTES_DEF   256
`define BMMD_OFF_INDIRECT_DATA_PORT        7'h00
`define BMMD_OFF_PCL         7'h02
`define BMMD_OFF_STATUS      7'h03
`define BMMD_OFF_FSR         7'h04
`define BMMD_OFF_PROGRAM_COUNTER_LATCH_HIGH      7'h0a
`define BMMD_OFF_INTERRUPT_CONTROL      7'h0b
`define BMMD_GPR_BASE        7'h20
`define BMMD_SHARED_BASE     7'h70
`define BMMD_BANK0_PHYS      9'h000
`define BMMD_BANK1_PHYS      9'h060
`define BMMD_BANK2_PHYS      9'h0b0
`define BMMD_BANK3_PHYS      9'h100
`define BMMD_BANK0           2'h0
`define BMMD_BANK1           2'h1
`define BMMD_BANK2           2'h2

// ----------------------------------------------------------------------
// status fields and reset values
// ----------------------------------------------------------------------
`define BMMD_STAT_RP_LSB     5
`define BMMD_STAT_RP_MSB     6
`define BMMD_STAT_IRP        7
`define BMMD_STATUS_RST      8'h00
`define BMMD_FSR_RST         8'h00
`define BMMD_PROGRAM_COUNTER_LATCH_HIGH_RST      8'h00
`define BMMD_INTERRUPT_CONTROL_RST      8'h00
`define BMMD_BYTE_ZERO       8'h00

`endif

// ### rtl/bmmd_pkg.sv
// types shared by the banked memory map decoder
package bmmd_pkg;

  // ----------------------------------------------------------------------
  // one data access as seen by the decoder
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [8:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bmmd_dacc_t;

  // ----------------------------------------------------------------------
  // region an effective address falls in
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    BMMD_RGN_CORE   = 2'b00,
    BMMD_RGN_PERIPH = 2'b01,
    BMMD_RGN_GPR    = 2'b10,
    BMMD_RGN_NONE   = 2'b11
  } bmmd_region_t;

endpackage

// ### rtl/bmmd_gpr_ram.sv
// general purpose storage array with registered read port
`timescale 1ns/10ps
`include "bmmd_params.svh"
module bmmd_gpr_ram #(
  parameter int DEPTH = 256,
  parameter int AW    = 8
) (
  input  wire logic          mclk_in,
  input  wire logic          rst_in,
  input  wire logic          ce_in,
  input  wire logic          wr_en_in,
  input  wire logic [AW-1:0] wr_addr_in,
  input  wire logic [7:0]    wr_data_in,
  input  wire logic          rd_en_in,
  input  wire logic [AW-1:0] rd_addr_in,
  input  wire logic          alt_sel_in,
  input  wire logic [7:0]    alt_data_in,
  output logic      [7:0]    rd_q_out
);

  logic [7:0] mem_q [DEPTH];
  logic [7:0] rd_d;

  // ----------------------------------------------------------------------
  // read path: array word or the decoder's own value, one flop deep
  // ----------------------------------------------------------------------
  assign rd_d = alt_sel_in ? alt_data_in : mem_q[rd_addr_in];

  // array has no reset so it maps onto plain ram
  always_ff @(posedge mclk_in) begin
    if (ce_in && wr_en_in) begin
      mem_q[wr_addr_in] <= wr_data_in;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_q_out <= `BMMD_BYTE_ZERO;
    end else if (ce_in && rd_en_in) begin
      rd_q_out <= rd_d;
    end
  end

endmodule // bmmd_gpr_ram

// ### rtl/bmmd_top.sv
// banked data memory decoder and program counter of the small core
`timescale 1ns/10ps
`include "bmmd_params.svh"
module bmmd_top
  import bmmd_pkg::*;
#(
  parameter int PROG_WORDS = `BMMD_PROG_WORDS_DEF,
  parameter int GPR_BYTES  = `BMMD_GPR_BYTES_DEF
) (
  input  wire logic                 mclk_in,
  input  wire logic                 rst_in,
  input  wire logic                 ce_in,
  input  wire logic [6:0]           data_offset_in,
  input  wire logic [7:0]           data_wdata_in,
  input  wire logic                 data_wr_in,
  input  wire logic                 data_rd_in,
  output logic      [7:0]           data_rdata_out,
  input  wire logic                 pc_step_in,
  input  wire logic                 pc_jump_in,
  input  wire logic [`BMMD_PC_W-1:0] pc_jump_addr_in,
  input  wire logic                 irq_vector_in,
  output logic      [`BMMD_PC_W-1:0] fetch_addr_out,
  output logic      [7:0]           status_out,
  output logic      [7:0]           fsr_out,
  output logic      [7:0]           program_counter_latch_high_out,
  output logic      [7:0]           interrupt_control_out,
  output logic                      periph_wr_out,
  output logic      [8:0]           periph_addr_out,
  output logic      [7:0]           periph_wdata_out
);

  // ----------------------------------------------------------------------
  // derived sizes
  // ----------------------------------------------------------------------
  // any capacity above 128 bytes takes a full 8-bit array index
  localparam int RAM_AW = (GPR_BYTES > 128) ? 8 : 7;
  localparam logic [8:0] GPR_LIM = 9'(GPR_BYTES);
  // wrap by masking only works for a power-of-two program size
  localparam logic [`BMMD_PC_W-1:0] PROG_MASK =
    `BMMD_PC_W'(PROG_WORDS - 1);

  // ----------------------------------------------------------------------
  // core special registers
  // ----------------------------------------------------------------------
  logic [`BMMD_PC_W-1:0] pc_q;
  logic [`BMMD_PC_W-1:0] pc_d;
  logic [`BMMD_PC_W-1:0] fetch_q;
  logic [7:0]            status_q;
  logic [7:0]            status_d;
  logic [7:0]            fsr_q;
  logic [7:0]            fsr_d;
  logic [7:0]            program_counter_latch_high_q;
  logic [7:0]            program_counter_latch_high_d;
  logic [7:0]            interrupt_control_q;
  logic [7:0]            interrupt_control_d;
  logic                  pwr_q;
  logic [8:0]            paddr_q;
  logic [7:0]            pwdata_q;

  // ----------------------------------------------------------------------
  // access carrier and effective address
  // ----------------------------------------------------------------------
  bmmd_dacc_t   acc;
  logic [1:0]   bank_select_bits;
  logic         bank_select_high;
  logic         bank_select_low;
  logic         indirect_bank;
  logic         is_indirect;
  logic [8:0]   eff_addr;
  logic [1:0]   eff_bank;
  logic [6:0]   eff_off;

  assign bank_select_bits = status_q[`BMMD_STAT_RP_MSB:`BMMD_STAT_RP_LSB];
  assign bank_select_high = bank_select_bits[1];
  assign bank_select_low  = bank_select_bits[0];
  // status bit 7 is the pointer's ninth bit, reaching banks 2 and 3
  assign indirect_bank    = status_q[`BMMD_STAT_IRP];

  // direct: bank bits above the instruction offset
  assign acc.addr  = {bank_select_high, bank_select_low,
                      data_offset_in};
  assign acc.wdata = data_wdata_in;
  assign acc.wr    = data_wr_in;
  assign acc.rd    = data_rd_in;

  // offset 0 in any bank redirects through the pointer
  assign is_indirect = (acc.addr[6:0] == `BMMD_OFF_INDIRECT_DATA_PORT);
  assign eff_addr    = is_indirect ? {indirect_bank, fsr_q}
                                   : acc.addr;
  assign eff_bank    = eff_addr[8:7];
  assign eff_off     = eff_addr[6:0];

  // ----------------------------------------------------------------------
  // region decode (bank is ignored for the core registers)
  // ----------------------------------------------------------------------
  logic sel_indirect_data_port;
  logic sel_pcl;
  logic sel_status;
  logic sel_fsr;
  logic sel_program_counter_latch_high;
  logic sel_interrupt_control;
  logic in_sfr;
  logic in_gpr;
  logic is_shared;
  bmmd_region_t region;

  assign sel_indirect_data_port   = (eff_off == `BMMD_OFF_INDIRECT_DATA_PORT);
  assign sel_pcl    = (eff_off == `BMMD_OFF_PCL);
  assign sel_status = (eff_off == `BMMD_OFF_STATUS);
  assign sel_fsr    = (eff_off == `BMMD_OFF_FSR);
  assign sel_program_counter_latch_high = (eff_off == `BMMD_OFF_PROGRAM_COUNTER_LATCH_HIGH);
  assign sel_interrupt_control = (eff_off == `BMMD_OFF_INTERRUPT_CONTROL);
  assign in_sfr     = (eff_off < `BMMD_GPR_BASE);
  assign in_gpr     = !in_sfr;
  assign is_shared  = (eff_bank != `BMMD_BANK0) &&
                      (eff_off >= `BMMD_SHARED_BASE);

  // ----------------------------------------------------------------------
  // physical index of a general purpose byte
  // ----------------------------------------------------------------------
  logic [8:0] gpr_rel;
  logic [8:0] bank_phys;
  logic [8:0] gpr_idx;
  logic       gpr_present;

  assign gpr_rel = {2'b00, eff_off} - {2'b00, `BMMD_GPR_BASE};

  // each bank's free bytes follow the previous bank's in one array
  always_comb begin
    if (is_shared || eff_bank == `BMMD_BANK0) begin
      bank_phys = `BMMD_BANK0_PHYS;
    end else if (eff_bank == `BMMD_BANK1) begin
      bank_phys = `BMMD_BANK1_PHYS;
    end else if (eff_bank == `BMMD_BANK2) begin
      bank_phys = `BMMD_BANK2_PHYS;
    end else begin
      bank_phys = `BMMD_BANK3_PHYS;
    end
  end

  assign gpr_idx     = bank_phys + gpr_rel;
  assign gpr_present = in_gpr && (gpr_idx < GPR_LIM);

  always_comb begin
    if (in_gpr) begin
      region = gpr_present ? BMMD_RGN_GPR : BMMD_RGN_NONE;
    end else if (sel_indirect_data_port && is_indirect) begin
      region = BMMD_RGN_NONE;
    end else if (sel_indirect_data_port || sel_pcl || sel_status || sel_fsr ||
                 sel_program_counter_latch_high || sel_interrupt_control) begin
      region = BMMD_RGN_CORE;
    end else begin
      region = BMMD_RGN_PERIPH;
    end
  end

  logic rgn_core;
  logic rgn_gpr;
  logic rgn_periph;

  assign rgn_core   = (region == BMMD_RGN_CORE);
  assign rgn_gpr    = (region == BMMD_RGN_GPR);
  assign rgn_periph = (region == BMMD_RGN_PERIPH);

  // ----------------------------------------------------------------------
  // write enables
  // ----------------------------------------------------------------------
  logic core_wr;
  logic wr_pcl;
  logic wr_status;
  logic wr_fsr;
  logic wr_program_counter_latch_high;
  logic wr_interrupt_control;
  logic wr_gpr;
  logic wr_periph;

  assign core_wr   = acc.wr && rgn_core;
  assign wr_pcl    = core_wr && sel_pcl;
  assign wr_status = core_wr && sel_status;
  assign wr_fsr    = core_wr && sel_fsr;
  assign wr_program_counter_latch_high = core_wr && sel_program_counter_latch_high;
  assign wr_interrupt_control = core_wr && sel_interrupt_control;
  // pointer aimed at offset 0 falls in region none and is dropped
  assign wr_gpr    = acc.wr && rgn_gpr;
  assign wr_periph = acc.wr && rgn_periph;

  // held until rewritten
  assign status_d = wr_status ? acc.wdata : status_q;
  assign fsr_d    = wr_fsr    ? acc.wdata : fsr_q;
  assign program_counter_latch_high_d = wr_program_counter_latch_high ? acc.wdata : program_counter_latch_high_q;
  assign interrupt_control_d = wr_interrupt_control ? acc.wdata : interrupt_control_q;

  // ----------------------------------------------------------------------
  // read value for everything outside the array
  // ----------------------------------------------------------------------
  logic [7:0] core_rd;
  logic       alt_sel;

  always_comb begin
    if (sel_pcl) begin
      core_rd = pc_q[7:0];
    end else if (sel_status) begin
      core_rd = status_q;
    end else if (sel_fsr) begin
      core_rd = fsr_q;
    end else if (sel_program_counter_latch_high) begin
      core_rd = program_counter_latch_high_q;
    end else if (sel_interrupt_control) begin
      core_rd = interrupt_control_q;
    end else begin
      core_rd = `BMMD_BYTE_ZERO;
    end
  end

  // peripheral registers live outside, so their reads give zero here
  logic [7:0] alt_data;
  assign alt_sel  = !rgn_gpr;
  assign alt_data = rgn_core ? core_rd
                             : `BMMD_BYTE_ZERO;

  // ----------------------------------------------------------------------
  // program counter
  // ----------------------------------------------------------------------
  logic [`BMMD_PC_W-1:0] pc_raw;
  logic [`BMMD_PC_W-1:0] pc_inc;

  assign pc_inc = pc_q + `BMMD_PC_ONE;

  // an interrupt outranks any jump so the vector is never lost
  always_comb begin
    if (irq_vector_in) begin
      pc_raw = `BMMD_IRQ_VEC;
    end else if (wr_pcl) begin
      pc_raw = {program_counter_latch_high_q[`BMMD_PROGRAM_COUNTER_LATCH_HIGH_PC_W-1:0], acc.wdata};
    end else if (pc_jump_in) begin
      pc_raw = pc_jump_addr_in;
    end else if (pc_step_in) begin
      pc_raw = pc_inc;
    end else begin
      pc_raw = pc_q;
    end
  end

  // upper bits dropped: fetches past the top land in present memory
  assign pc_d = pc_raw & PROG_MASK;

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      pc_q    <= `BMMD_RESET_VEC;
      fetch_q <= `BMMD_RESET_VEC;
    end else if (ce_in) begin
      pc_q    <= pc_d;
      fetch_q <= pc_d;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      status_q <= `BMMD_STATUS_RST;
      fsr_q    <= `BMMD_FSR_RST;
      program_counter_latch_high_q <= `BMMD_PROGRAM_COUNTER_LATCH_HIGH_RST;
      interrupt_control_q <= `BMMD_INTERRUPT_CONTROL_RST;
    end else if (ce_in) begin
      status_q <= status_d;
      fsr_q    <= fsr_d;
      program_counter_latch_high_q <= program_counter_latch_high_d;
      interrupt_control_q <= interrupt_control_d;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      pwr_q    <= 1'b0;
      paddr_q  <= 9'h000;
      pwdata_q <= `BMMD_BYTE_ZERO;
    end else if (ce_in) begin
      // pulse only; address and data hold for the peripheral side
      pwr_q <= wr_periph;
      if (wr_periph) begin
        paddr_q  <= eff_addr;
        pwdata_q <= acc.wdata;
      end
    end
  end

  // ----------------------------------------------------------------------
  // general purpose array
  // ----------------------------------------------------------------------
  logic [RAM_AW-1:0] ram_addr;
  logic [7:0]        ram_q;

  assign ram_addr = gpr_idx[RAM_AW-1:0];

  // one index serves both ports since the strobes never coincide
  bmmd_gpr_ram #(
    .DEPTH (GPR_BYTES),
    .AW    (RAM_AW)
  ) u_gpr_ram (
    .mclk_in     (mclk_in),
    .rst_in      (rst_in),
    .ce_in       (ce_in),
    .wr_en_in    (wr_gpr),
    .wr_addr_in  (ram_addr),
    .wr_data_in  (acc.wdata),
    .rd_en_in    (acc.rd),
    .rd_addr_in  (ram_addr),
    .alt_sel_in  (alt_sel),
    .alt_data_in (alt_data),
    .rd_q_out    (ram_q)
  );

  // ----------------------------------------------------------------------
  // outputs, each a flop
  // ----------------------------------------------------------------------
  assign data_rdata_out   = ram_q;
  assign fetch_addr_out   = fetch_q;
  assign status_out       = status_q;
  assign fsr_out          = fsr_q;
  assign program_counter_latch_high_out       = program_counter_latch_high_q;
  assign interrupt_control_out       = interrupt_control_q;
  assign periph_wr_out    = pwr_q;
  assign periph_addr_out  = paddr_q;
  assign periph_wdata_out = pwdata_q;

endmodule // bmmd_top

// ### dv/bmmd_top_chk.sv
// concurrent checks on the ports of the banked memory map decoder
`timescale 1ns/10ps
`include "bmmd_params.svh"
module bmmd_top_chk
  import bmmd_pkg::*;
#(
  parameter int PROG_WORDS = 4096
) (
  input wire logic                  mclk_in,
  input wire logic                  rst_in,
  input wire logic                  ce_in,
  input wire logic [6:0]            data_offset_in,
  input wire logic [7:0]            data_wdata_in,
  input wire logic                  data_wr_in,
  input wire logic                  data_rd_in,
  input wire logic [7:0]            data_rdata_out,
  input wire logic                  pc_step_in,
  input wire logic                  pc_jump_in,
  input wire logic [`BMMD_PC_W-1:0] pc_jump_addr_in,
  input wire logic                  irq_vector_in,
  input wire logic [`BMMD_PC_W-1:0] fetch_addr_out,
  input wire logic [7:0]            status_out,
  input wire logic                  periph_wr_out,
  input wire logic [8:0]            periph_addr_out
);
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);

  wire logic [6:0]  off = data_offset_in;
  wire logic        is_core = off inside {7'h00, 7'h02, 7'h03, 7'h04,
                                          7'h0a, 7'h0b};
  wire logic        is_periph = (off < 7'h20) && !is_core;
  wire logic        pcl_wr = ce_in && data_wr_in && (off == 7'h02);
  wire logic [12:0] mask = 13'(PROG_WORDS - 1);

  sequence s_fsr_wr;
    ce_in && data_wr_in && (off == `BMMD_OFF_FSR);
  endsequence
  sequence s_fsr_rd;
    ce_in && data_rd_in && (off == `BMMD_OFF_FSR);
  endsequence

  property p_pc_step;
    ce_in && pc_step_in && !pc_jump_in && !irq_vector_in && !pcl_wr
      |=> fetch_addr_out == (($past(fetch_addr_out) + 13'h0001) & mask);
  endproperty
  a_pc_step: assert property (p_pc_step)
    else $error("fetch address did not step");
  property p_jump;
    ce_in && pc_jump_in && !irq_vector_in && !pcl_wr
      |=> fetch_addr_out == ($past(pc_jump_addr_in) & mask);
  endproperty
  a_jump: assert property (p_jump)
    else $error("jump target not masked");
  property p_irq;
    ce_in && irq_vector_in |=> fetch_addr_out == `BMMD_IRQ_VEC;
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt vector wrong");
  property p_freeze;
    !ce_in |=> $stable(fetch_addr_out) && $stable(status_out);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("state moved with enable low");
  property p_status;
    ce_in && data_wr_in && (off == `BMMD_OFF_STATUS)
      |=> status_out == $past(data_wdata_in);
  endproperty
  a_status: assert property (p_status)
    else $error("status write lost");
  property p_rd_periph;
    ce_in && data_rd_in && is_periph |=> data_rdata_out == 8'h00;
  endproperty
  a_rd_periph: assert property (p_rd_periph)
    else $error("peripheral offset read not zero");
  property p_periph_wr;
    ce_in && data_wr_in && is_periph |=> periph_wr_out &&
      periph_addr_out == {$past(status_out[6:5]), $past(off)};
  endproperty
  a_periph_wr: assert property (p_periph_wr)
    else $error("peripheral write address wrong");
  property p_no_periph;
    ce_in && !(data_wr_in && (is_periph || off == `BMMD_OFF_INDIRECT_DATA_PORT))
      |=> !periph_wr_out;
  endproperty
  a_no_periph: assert property (p_no_periph)
    else $error("stray peripheral write pulse");
  property p_fsr;
    s_fsr_wr ##2 s_fsr_rd |=> data_rdata_out == $past(data_wdata_in, 3);
  endproperty
  a_fsr: assert property (p_fsr)
    else $error("pointer readback wrong");
endmodule // bmmd_top_chk

bind bmmd_top bmmd_top_chk #(.PROG_WORDS(PROG_WORDS)) bmmd_top_chk_i (
  .mclk_in, .rst_in, .ce_in, .data_offset_in, .data_wdata_in,
  .data_wr_in, .data_rd_in, .data_rdata_out, .pc_step_in, .pc_jump_in,
  .pc_jump_addr_in, .irq_vector_in, .fetch_addr_out, .status_out,
  .periph_wr_out, .periph_addr_out
);

// ### dv/bmmd_core_model.sv
// processor core model issuing data accesses and fetch control
`timescale 1ns/10ps
module bmmd_core_model (
  input  wire logic        mclk_in,
  output logic             ce_out,
  output logic [6:0]       offset_out,
  output logic [7:0]       wdata_out,
  output logic             wr_out,
  output logic             rd_out,
  input  wire logic [7:0]  rdata_in,
  output logic             step_out,
  output logic             jump_out,
  output logic [12:0]      jaddr_out,
  output logic             irq_out
);
  initial begin
    ce_out = 1'b1;
    offset_out = 7'h00;
    wdata_out = 8'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
    step_out = 1'b0;
    jump_out = 1'b0;
    jaddr_out = 13'h0000;
    irq_out = 1'b0;
  end
  // released address and data lines invert so no stale value passes for a live one
  task automatic wr(input logic [6:0] off, input logic [7:0] d);
    @(posedge mclk_in);
    wr_out     <= 1'b1;
    offset_out <= off;
    wdata_out  <= d;
    @(posedge mclk_in);
    wr_out     <= 1'b0;
    offset_out <= ~off;
    wdata_out  <= ~d;
    #1;
  endtask
  task automatic rd(input logic [6:0] off, output logic [7:0] d);
    @(posedge mclk_in);
    rd_out     <= 1'b1;
    offset_out <= off;
    @(posedge mclk_in);
    rd_out     <= 1'b0;
    offset_out <= ~off;
    #1;
    d = rdata_in;
  endtask
  task automatic pc(input logic ce, input logic st, input logic jp,
                    input logic [12:0] a, input logic irq);
    @(posedge mclk_in);
    ce_out    <= ce;
    step_out  <= st;
    jump_out  <= jp;
    jaddr_out <= a;
    irq_out   <= irq;
    @(posedge mclk_in);
    ce_out    <= 1'b1;
    step_out  <= 1'b0;
    jump_out  <= 1'b0;
    jaddr_out <= ~a;
    irq_out   <= 1'b0;
    #1;
  endtask
endmodule // bmmd_core_model

// ### dv/tb_bmmd_top.sv
// self-checking bench for the banked memory map decoder
`timescale 1ns/10ps
module tb_bmmd_top;
  import bmmd_pkg::*;
  // small program space so wrap is reached quickly
  localparam int PW = 1024;
  logic        mclk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        ce, wr, rd, step, jump, irq, pwr;
  logic [6:0]  off;
  logic [7:0]  wd, rdat, st, file_select_pointer, plh, pwd, v, ic;
  logic [12:0] ja, fa;
  logic [8:0]  pad;
  int          failures = 0;
  int          n_compared = 0;

  always #5 mclk_in = ~mclk_in;

  bmmd_core_model bmmd_core_model_i (
    .mclk_in(mclk_in), .ce_out(ce), .offset_out(off), .wdata_out(wd),
    .wr_out(wr), .rd_out(rd), .rdata_in(rdat), .step_out(step),
    .jump_out(jump), .jaddr_out(ja), .irq_out(irq));
  bmmd_top #(.PROG_WORDS(PW), .GPR_BYTES(256)) bmmd_top_i (
    .mclk_in(mclk_in), .rst_in(rst_in), .ce_in(ce),
    .data_offset_in(off), .data_wdata_in(wd), .data_wr_in(wr),
    .data_rd_in(rd), .data_rdata_out(rdat), .pc_step_in(step),
    .pc_jump_in(jump), .pc_jump_addr_in(ja), .irq_vector_in(irq),
    .fetch_addr_out(fa), .status_out(st), .fsr_out(file_select_pointer),
    .program_counter_latch_high_out(plh), .interrupt_control_out(ic), .periph_wr_out(pwr),
    .periph_addr_out(pad), .periph_wdata_out(pwd));

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rd_chk(input logic [6:0] o, input logic [7:0] e);
    bmmd_core_model_i.rd(o, v);
    chk("read data", {8'h00, e}, {8'h00, v});
  endtask
  task automatic bank(input logic [1:0] b);
    bmmd_core_model_i.wr(7'h03, {1'b0, b, 5'h00});
    chk("status", {9'h000, b, 5'h00}, {8'h00, st});
  endtask
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    #100us;
    failures++;
    conclude();
  end

  initial begin
    repeat (3) @(posedge mclk_in);
    rst_in <= 1'b0;
    #1;
    chk("fetch", 16'h0000, {3'b000, fa});
    // ----------------------------------------------------------------
    // banks, shared window, boundaries
    // ----------------------------------------------------------------
    for (int b = 0; b < 4; b++) begin
      bank(2'(b));
      bmmd_core_model_i.wr(7'h30, 8'h10 + 8'(b));
      bmmd_core_model_i.wr(7'h7f, 8'ha0 + 8'(b));
    end
    for (int b = 0; b < 4; b++) begin
      bank(2'(b));
      rd_chk(7'h30, (b == 3) ? 8'h00 : 8'h10 + 8'(b));
      rd_chk(7'h7f, 8'ha3);
    end
    bank(2'h0);
    bmmd_core_model_i.wr(7'h20, 8'h3c);
    rd_chk(7'h20, 8'h3c);
    $display("test banks done");
    // ----------------------------------------------------------------
    // core registers and pointer access
    // ----------------------------------------------------------------
    bank(2'h3);
    bmmd_core_model_i.wr(7'h04, 8'h35);
    rd_chk(7'h04, 8'h35);
    bank(2'h0);
    chk("pointer", 16'h0035, {8'h00, file_select_pointer});
    bmmd_core_model_i.wr(7'h35, 8'h5a);
    rd_chk(7'h00, 8'h5a);
    bmmd_core_model_i.wr(7'h00, 8'hc3);
    rd_chk(7'h35, 8'hc3);
    // pointer ninth bit set, bank 2 active: indirect and direct meet
    bmmd_core_model_i.wr(7'h03, 8'hc0);
    bmmd_core_model_i.wr(7'h00, 8'h96);
    rd_chk(7'h35, 8'h96);
    bmmd_core_model_i.wr(7'h0b, 8'h81);
    chk("interrupt_control", 16'h0081, {8'h00, ic});
    rd_chk(7'h0b, 8'h81);
    bank(2'h1);
    bmmd_core_model_i.wr(7'h1f, 8'h77);
    chk("periph strobe", 16'h0001, {15'h0000, pwr});
    chk("periph addr", 16'h009f, {7'h00, pad});
    chk("periph data", 16'h0077, {8'h00, pwd});
    rd_chk(7'h1f, 8'h00);
    $display("test core done");
    // ----------------------------------------------------------------
    // program counter
    // ----------------------------------------------------------------
    bmmd_core_model_i.pc(1'b1, 1'b1, 1'b0, 13'h0000, 1'b0);
    chk("fetch", 16'h0001, {3'b000, fa});
    bmmd_core_model_i.pc(1'b1, 1'b0, 1'b1, 13'h1fff, 1'b0);
    chk("fetch", 16'h03ff, {3'b000, fa});
    bmmd_core_model_i.pc(1'b1, 1'b1, 1'b0, 13'h0000, 1'b0);
    chk("fetch", 16'h0000, {3'b000, fa});
    bmmd_core_model_i.pc(1'b0, 1'b1, 1'b0, 13'h0000, 1'b0);
    chk("fetch", 16'h0000, {3'b000, fa});
    bmmd_core_model_i.pc(1'b1, 1'b0, 1'b1, 13'h0123, 1'b1);
    chk("fetch", 16'h0004, {3'b000, fa});
    rd_chk(7'h02, 8'h04);
    bmmd_core_model_i.wr(7'h0a, 8'h02);
    chk("latch", 16'h0002, {8'h00, plh});
    bmmd_core_model_i.wr(7'h02, 8'h10);
    chk("fetch", 16'h0210, {3'b000, fa});
    $display("test pc done");
    conclude();
  end
endmodule // tb_bmmd_top
